//--- pwmoc_output_control.sv
// PWM output control: pin ownership, overrides, external reset, sync out
//
// Our own choices: register access over APB and the address map.
`default_nettype none
module pwmoc_output_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_period_reset,
  input wire logic gpio_high_out,
  input wire logic gpio_high_oe,
  input wire logic gpio_low_out,
  input wire logic gpio_low_oe,
  output logic high_side_output,
  output logic high_side_oe,
  output logic low_side_output,
  output logic low_side_oe,
  output logic secondary_sync_out
);
  // ---------------------------------------------------------------
  // Pin drive selection
  // ---------------------------------------------------------------
  function automatic logic [1:0] pin_drive(input logic owner, input logic ovr_en,
      input logic ovr_lvl, input logic wave, input logic gp_val, input logic gp_oe);
    logic [1:0] r;
    r = {gp_val, gp_oe};
    if (owner) begin
      r = {(ovr_en ? ovr_lvl : wave), 1'b1};
    end
    return r;
  endfunction

  logic [15:0] pin_io_control_reg, pin_io_control_next;
  logic [15:0] pwm_time_base_control_reg, pwm_time_base_control_next;
  logic [15:0] period_reg, period_next;
  logic [15:0] duty_reg, duty_next;
  logic [15:0] sec_period_reg, sec_period_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic ext_block_reg, ext_block_next;
  logic [3:0] sync_cnt_reg, sync_cnt_next;
  logic sync_out_reg, sync_out_next;
  logic high_reg, high_next, high_oe_reg, high_oe_next;
  logic low_reg, low_next, low_oe_reg, low_oe_next;
  logic [15:0] pri_count, sec_count;
  logic pri_start, sec_start;
  logic module_enable_bit, ext_mode, sync_enable;
  logic high_pin_owner, low_pin_owner;
  logic high_override_enable, low_override_enable;
  logic [1:0] override_levels;
  logic on_phase, ext_restart, wave;
  logic access, hit;
  logic wr_commit;
  logic [31:0] rd_word;

  assign module_enable_bit = pwm_time_base_control_reg[pwmoc_pkg::MODULE_ENABLE_BIT];
  assign ext_mode = pwm_time_base_control_reg[pwmoc_pkg::EXT_RESET_MODE_BIT];
  assign sync_enable = pwm_time_base_control_reg[pwmoc_pkg::SYNC_ENABLE_BIT];
  assign high_pin_owner = pin_io_control_reg[pwmoc_pkg::HIGH_PIN_OWNER_BIT];
  assign low_pin_owner = pin_io_control_reg[pwmoc_pkg::LOW_PIN_OWNER_BIT];
  assign high_override_enable = pin_io_control_reg[pwmoc_pkg::HIGH_OVERRIDE_ENABLE_BIT];
  assign low_override_enable = pin_io_control_reg[pwmoc_pkg::LOW_OVERRIDE_ENABLE_BIT];
  assign override_levels =
      pin_io_control_reg[pwmoc_pkg::OVERRIDE_LEVELS_HI:pwmoc_pkg::OVERRIDE_LEVELS_LO];

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign access = psel && penable && !pready_reg;
  assign wr_commit = psel && penable && pready_reg && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      pwmoc_pkg::ADDR_PIN_IO_CONTROL: rd_word = {16'h0000, pin_io_control_reg};
      pwmoc_pkg::ADDR_TIME_BASE_CONTROL: rd_word = {16'h0000, pwm_time_base_control_reg};
      pwmoc_pkg::ADDR_PERIOD: rd_word = {16'h0000, period_reg};
      pwmoc_pkg::ADDR_DUTY: rd_word = {16'h0000, duty_reg};
      pwmoc_pkg::ADDR_SEC_PERIOD: rd_word = {16'h0000, sec_period_reg};
      pwmoc_pkg::ADDR_STATUS: rd_word = {pri_count, 13'h0000, ext_block_reg, sync_out_reg,
                                         on_phase};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    pin_io_control_next = pin_io_control_reg;
    pwm_time_base_control_next = pwm_time_base_control_reg;
    period_next = period_reg;
    duty_next = duty_reg;
    sec_period_next = sec_period_reg;
    pready_next = access;
    pslverr_next = access && !hit;
    prdata_next = 32'h0000_0000;
    if (access && !pwrite) begin
      prdata_next = rd_word;
    end
    // Write lands on the edge that completes the transfer
    if (wr_commit) begin
      unique case (paddr)
        // Pin owners, overrides and levels
        // control bits stored
        pwmoc_pkg::ADDR_PIN_IO_CONTROL: pin_io_control_next = pwdata[15:0];
        pwmoc_pkg::ADDR_TIME_BASE_CONTROL: pwm_time_base_control_next = pwdata[15:0];
        pwmoc_pkg::ADDR_PERIOD: period_next = pwdata[15:0];
        pwmoc_pkg::ADDR_DUTY: duty_next = pwdata[15:0];
        pwmoc_pkg::ADDR_SEC_PERIOD: sec_period_next = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_io_control_reg <= pwmoc_pkg::PIN_IO_CONTROL_RESET;
      pwm_time_base_control_reg <= pwmoc_pkg::TIME_BASE_CONTROL_RESET;
      period_reg <= pwmoc_pkg::PERIOD_RESET;
      duty_reg <= pwmoc_pkg::DUTY_RESET;
      sec_period_reg <= pwmoc_pkg::SEC_PERIOD_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pin_io_control_reg <= pin_io_control_next;
      pwm_time_base_control_reg <= pwm_time_base_control_next;
      period_reg <= period_next;
      duty_reg <= duty_next;
      sec_period_reg <= sec_period_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------
  // Time bases
  // ---------------------------------------------------------------
  // both time bases run only while enabled
  pwmoc_time_base u_primary (
    .pclk(pclk),
    .presetn(presetn),
    .run(module_enable_bit),
    .restart(ext_restart),
    .period(period_reg),
    .count(pri_count),
    .start(pri_start)
  );

  pwmoc_time_base u_secondary (
    .pclk(pclk),
    .presetn(presetn),
    .run(module_enable_bit),
    .restart(1'b0),
    .period(sec_period_reg),
    .count(sec_count),
    .start(sec_start)
  );

  assign on_phase = module_enable_bit && (pri_count < duty_reg);
  assign wave = on_phase;

  // ---------------------------------------------------------------
  // External period reset
  // ---------------------------------------------------------------
  // restart only when seen in the off time
  assign ext_restart = ext_mode && module_enable_bit && ext_period_reset && !on_phase
                       && !ext_block_reg;

  always_comb begin
    // a reset held from the on time stays blocked until released
    ext_block_next = ext_period_reset && (on_phase || ext_block_reg);
    sync_cnt_next = 4'h0;
    if (sec_start && sync_enable) begin
      sync_cnt_next = pwmoc_pkg::SYNC_PULSE_CYCLES;
    end else if (sync_cnt_reg != 4'h0) begin
      sync_cnt_next = sync_cnt_reg - 4'h1;
    end
    // sync pulse from the secondary time base
    sync_out_next = sync_cnt_next != 4'h0;
    {high_next, high_oe_next} = pin_drive(high_pin_owner, high_override_enable,
        override_levels[1], wave, gpio_high_out, gpio_high_oe);
    {low_next, low_oe_next} = pin_drive(low_pin_owner, low_override_enable,
        override_levels[0], module_enable_bit && !wave, gpio_low_out, gpio_low_oe);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_block_reg <= 1'b0;
      sync_cnt_reg <= 4'h0;
      sync_out_reg <= 1'b0;
      high_reg <= 1'b0;
      high_oe_reg <= 1'b0;
      low_reg <= 1'b0;
      low_oe_reg <= 1'b0;
    end else begin
      ext_block_reg <= ext_block_next;
      sync_cnt_reg <= sync_cnt_next;
      sync_out_reg <= sync_out_next;
      high_reg <= high_next;
      high_oe_reg <= high_oe_next;
      low_reg <= low_next;
      low_oe_reg <= low_oe_next;
    end
  end

  // ---------------------------------------------------------------
  // Register outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign high_side_output = high_reg;
  assign high_side_oe = high_oe_reg;
  assign low_side_output = low_reg;
  assign low_side_oe = low_oe_reg;
  assign secondary_sync_out = sync_out_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  restart_off_a: assert property (
    ext_mode && module_enable_bit && ext_period_reset && !on_phase && !ext_block_reg
    |=> pri_count == 16'h0000 && pri_start)
    else $error("off-time external reset did not restart period");

  ignore_on_a: assert property (
    module_enable_bit && ext_period_reset && (on_phase || ext_block_reg)
    && pri_count < period_reg
    |=> pri_count == $past(pri_count) + 16'h0001)
    else $error("external reset held from on time restarted period");

  owner_high_a: assert property (
    !high_pin_owner |=> high_side_output == $past(gpio_high_out)
    && high_side_oe == $past(gpio_high_oe))
    else $error("GPIO-owned high pin not following GPIO");

  owner_low_a: assert property (
    low_pin_owner |=> low_side_oe)
    else $error("PWM-owned low pin not driven");

  enable_run_a: assert property (
    !module_enable_bit |=> pri_count == 16'h0000 && sec_count == 16'h0000)
    else $error("time base ran while disabled");

  override_high_a: assert property (
    high_pin_owner && high_override_enable
    |=> high_side_output == $past(override_levels[1]) && high_side_oe)
    else $error("high override level wrong");

  override_low_a: assert property (
    low_pin_owner && low_override_enable
    |=> low_side_output == $past(override_levels[0]))
    else $error("low override level wrong");

  wave_pass_a: assert property (
    high_pin_owner && !high_override_enable |=> high_side_output == $past(on_phase))
    else $error("waveform not on high pin without override");

  sync_width_a: assert property (
    sec_start && sync_enable |=> secondary_sync_out [*2])
    else $error("sync pulse too short");

  low_wave_a: assert property (
    low_pin_owner && !low_override_enable
    |=> low_side_output == $past(module_enable_bit && !on_phase))
    else $error("waveform not on low pin without override");

  gpio_low_a: assert property (
    !low_pin_owner |=> low_side_output == $past(gpio_low_out)
    && low_side_oe == $past(gpio_low_oe))
    else $error("GPIO-owned low pin not following GPIO");

  start_cause_a: assert property (
    pri_start |-> $past(ext_restart) || $past(pri_count) >= $past(period_reg))
    else $error("period restarted with no cause");

  enable_count_a: assert property (
    module_enable_bit && !ext_restart && pri_count < period_reg
    |=> pri_count == $past(pri_count) + 16'h0001)
    else $error("enabled time base did not count");

  disabled_high_a: assert property (
    high_pin_owner && !high_override_enable && !module_enable_bit |=> !high_side_output)
    else $error("high pin pulsed while module disabled");

  sync_off_a: assert property (
    !sync_enable && sync_cnt_reg == 4'h0 |=> !secondary_sync_out)
    else $error("sync pulse while sync output disabled");

  sync_source_a: assert property (
    $rose(secondary_sync_out) |-> $past(sec_start && sync_enable))
    else $error("sync pulse without secondary period start");
endmodule
`default_nettype wire

//--- pwmoc_pkg.sv
// Constants and register map for the PWM output control block
// Summary of operation
// - With external period reset mode on, an external reset seen in the off time restarts the period.
// - An external reset held through the on time is ignored and gives no restart when the on time ends.
// - Bits 15 and 14 of the pin control register give the high and low pins to the PWM when 1, to GPIO when 0.
// - Bit 15 of the time base control register starts the time base and generator outputs when 1.
// - A two-bit override level field sets the pin levels while an override is active.
// - Override enables at bits 9 (high) and 8 (low) replace the waveform with the override level.
// - A sync output pulses from the secondary time base so another device can follow it.
`default_nettype none
package pwmoc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_IO_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIME_BASE_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DUTY = 8'h0c;
  localparam logic [7:0] ADDR_SEC_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HIGH_PIN_OWNER_BIT = 15;
  localparam int LOW_PIN_OWNER_BIT = 14;
  localparam int HIGH_OVERRIDE_ENABLE_BIT = 9;
  localparam int LOW_OVERRIDE_ENABLE_BIT = 8;
  localparam int OVERRIDE_LEVELS_HI = 7;
  localparam int OVERRIDE_LEVELS_LO = 6;
  localparam int MODULE_ENABLE_BIT = 15;
  localparam int SYNC_ENABLE_BIT = 1;
  localparam int EXT_RESET_MODE_BIT = 0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PIN_IO_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] TIME_BASE_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h00ff;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [15:0] SEC_PERIOD_RESET = 16'h00ff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_PULSE_NS = 100;
  localparam int SYNC_PULSE_CYCLES_I = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SYNC_PULSE_CYCLES = 4'(SYNC_PULSE_CYCLES_I);
endpackage
`default_nettype wire

//--- pwmoc_time_base.sv
// Period counter shared by the primary and secondary time bases
`default_nettype none
module pwmoc_time_base (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [15:0] period,
  output logic [15:0] count,
  output logic start
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic start_reg;
  logic start_next;

  always_comb begin
    count_next = count_reg + 16'h0001;
    start_next = 1'b0;
    if (!run) begin
      count_next = 16'h0000;
    end else if (restart || count_reg >= period) begin
      count_next = 16'h0000;
      start_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
      start_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      start_reg <= start_next;
    end
  end

  assign count = count_reg;
  assign start = start_reg;
endmodule
`default_nettype wire

//--- pwmoc_far_side.sv
// Far-side model: pulled-down switch inputs and a slave sync receiver
`default_nettype none
module pwmoc_far_side (
  input wire logic pclk,
  input wire logic high_side_output,
  input wire logic high_side_oe,
  input wire logic low_side_output,
  input wire logic low_side_oe,
  input wire logic secondary_sync_out,
  output logic high_pin,
  output logic low_pin,
  output int sync_pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sync_last = 1'b0;
  assign high_pin = high_side_oe ? high_side_output : 1'b0;
  assign low_pin = low_side_oe ? low_side_output : 1'b0;
  always @(posedge pclk) begin
    if (secondary_sync_out === 1'b1 && sync_last === 1'b0) begin
      sync_pulses <= sync_pulses + 1;
    end
    sync_last <= secondary_sync_out;
  end
endmodule
`default_nettype wire

//--- tb_pwm_output_control_sync.sv
// Self-checking bench for the PWM output control block
`default_nettype none
module tb_pwm_output_control_sync;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, ext_period_reset, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] gpio_v;
  logic [15:0] v;
  wire logic pready, pslverr, hs_out, hs_oe, ls_out, ls_oe, sync_out, high_pin, low_pin;
  wire logic [3:0] pins_seen;
  int sync_pulses, failures, checks, n, m, hi_cnt, lo_cnt, sy_cnt;
  int model_reg [6];
  assign pins_seen = {hs_oe, hs_out, ls_oe, ls_out};
  pwmoc_output_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_period_reset(ext_period_reset), .gpio_high_out(gpio_v[2]),
    .gpio_high_oe(gpio_v[3]), .gpio_low_out(gpio_v[0]), .gpio_low_oe(gpio_v[1]),
    .high_side_output(hs_out), .high_side_oe(hs_oe), .low_side_output(ls_out),
    .low_side_oe(ls_oe), .secondary_sync_out(sync_out));
  pwmoc_far_side far (.pclk(pclk), .high_side_output(hs_out), .high_side_oe(hs_oe),
    .low_side_output(ls_out), .low_side_oe(ls_oe), .secondary_sync_out(sync_out),
    .high_pin(high_pin), .low_pin(low_pin), .sync_pulses(sync_pulses));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a < 8'h14) model_reg[a >> 2] = int'(d[15:0]);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, (a < 8'h14) ? 32'(model_reg[a >> 2]) : 32'h0);
    chk(32'(err), 32'(a > 8'h14));
  endtask
  task automatic wait_high(input logic val, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (hs_out !== val && cnt < 100);
    if (hs_out !== val) failures++;
  endtask
  task automatic sample_win(input int len);
    hi_cnt = 0;
    lo_cnt = 0;
    sy_cnt = 0;
    repeat (len) begin
      @(posedge pclk);
      hi_cnt += (hs_out === 1'b1) ? 1 : 0;
      lo_cnt += (ls_out === 1'b1) ? 1 : 0;
      sy_cnt += (sync_out === 1'b1) ? 1 : 0;
    end
  endtask
  function automatic logic [3:0] exp_pins(input logic [15:0] c, input logic [3:0] g);
    exp_pins[3:2] = c[15] ? {1'b1, c[9] & c[7]} : g[3:2];
    exp_pins[1:0] = c[14] ? {1'b1, c[8] & c[6]} : g[1:0];
  endfunction
  task automatic give_verdict();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, ext_period_reset, paddr, pwdata, gpio_v} = '0;
    model_reg = '{0, 0, 255, 0, 255, 0};
    void'($urandom(32'h0182a8cc));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) if (a != 8'h14) rd_chk(8'(a));
    apb(1'b1, 8'h18, 32'hffff);
    chk(32'(err), 32'h1);
    rd_chk(8'h00);
    // owners and overrides set with module off
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom) & 16'hc3c0;
      v[9] = v[9] & v[15];
      v[8] = v[8] & v[14];
      gpio_v <= 4'($urandom);
      apb(1'b1, 8'h00, {16'($urandom), v});
      rd_chk(8'h00);
      repeat (2) @(posedge pclk);
      chk(pins_seen, exp_pins(v, gpio_v));
    end
    apb(1'b1, 8'h08, 32'd19);
    apb(1'b1, 8'h0c, 32'd4);
    // GPIO owns, pins released to pulls, safe levels, overrides on
    gpio_v <= 4'h0;
    apb(1'b1, 8'h00, 32'h0300);
    apb(1'b1, 8'h04, 32'h8001);
    chk({high_pin, low_pin, hs_oe, ls_oe}, 32'h0);
    // overrides off, one period, pins to PWM
    apb(1'b1, 8'h00, 32'h0000);
    repeat (20) @(posedge pclk);
    apb(1'b1, 8'h00, 32'hc000);
    repeat (2) @(posedge pclk);
    sample_win(model_reg[2] + 1);
    chk(hi_cnt, model_reg[3]);
    chk(lo_cnt, model_reg[2] + 1 - model_reg[3]);
    apb(1'b1, 8'h00, 32'hc380);
    repeat (2) @(posedge pclk);
    sample_win(20);
    chk(hi_cnt, 32'd20);
    chk(lo_cnt, 32'd0);
    chk({high_pin, low_pin}, 32'h2);
    apb(1'b1, 8'h00, 32'hc000);
    wait_high(1'b1, n);
    wait_high(1'b0, n);
    // reset source pulsed in the off time, then raised in the on time and held
    ext_period_reset <= 1'b1;
    @(posedge pclk);
    ext_period_reset <= 1'b0;
    wait_high(1'b1, n);
    chk(32'(n < 8), 32'h1);
    wait_high(1'b1, n);
    ext_period_reset <= 1'b1;
    wait_high(1'b0, n);
    wait_high(1'b1, m);
    // One on-time edge passed before the reset rose
    chk(n + m + 1, model_reg[2] + 1);
    ext_period_reset <= 1'b0;
    apb(1'b1, 8'h10, 32'd7);
    apb(1'b1, 8'h04, 32'h8003);
    repeat (300) @(posedge pclk);
    n = sync_pulses;
    sample_win(32);
    chk(sync_pulses - n, 32 / (model_reg[4] + 1));
    chk(sy_cnt, 2 * 32 / (model_reg[4] + 1));
    apb(1'b1, 8'h04, 32'h8000);
    repeat (4) @(posedge pclk);
    sample_win(32);
    chk(sy_cnt, 0);
    // mode off: an off-time reset does not restart
    wait_high(1'b1, n);
    wait_high(1'b0, n);
    ext_period_reset <= 1'b1;
    wait_high(1'b1, n);
    ext_period_reset <= 1'b0;
    chk(n, model_reg[2] + 1 - model_reg[3]);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
